// ---- shared/fcit_pkg.sv ----
// types shared by the interval timer modules
package fcit_pkg;

  // serial slave sequencing states
  typedef enum logic [2:0] {
    FCIT_ST_IDLE = 3'b000,
    FCIT_ST_ADDR = 3'b001,
    FCIT_ST_PTR = 3'b010,
    FCIT_ST_WDATA = 3'b011,
    FCIT_ST_RDATA = 3'b100,
    FCIT_ST_MACK = 3'b101
  } fcit_i2c_state_t;

  // countdown source choice
  typedef enum logic [1:0] {
    FCIT_SRC_4096 = 2'b00,
    FCIT_SRC_64 = 2'b01,
    FCIT_SRC_1 = 2'b10,
    FCIT_SRC_MIN = 2'b11
  } fcit_src_t;

endpackage

// ---- shared/fcit_reg_if.sv ----
// register access carrier between the serial slave and the timer core
`timescale 1ns/1ps
interface fcit_reg_if;
  logic wrStb;        // one-cycle write pulse
  logic [7:0] addr;   // register pointer
  logic [7:0] wrData; // byte written
  logic [7:0] rdData; // byte at pointer

  // serial side drives access
  modport bus (
    output wrStb,
    output addr,
    output wrData,
    input rdData
  );

  // register side answers
  modport regs (
    input wrStb,
    input addr,
    input wrData,
    output rdData
  );
endinterface

// ---- shared/fcit_regs.svh ----
// register offsets, field positions, reset values and timing counts of the interval timer
`ifndef FCIT_REGS_SVH
`define FCIT_REGS_SVH

// ****************************************
// register offsets
// ****************************************
`define FCIT_OFF_PRESET_LO 8'h0B
`define FCIT_OFF_PRESET_HI 8'h0C
`define FCIT_OFF_EXT_CTRL 8'h0D
`define FCIT_OFF_EVT_FLAGS 8'h0E
`define FCIT_OFF_IRQ_CTRL 8'h0F

// ****************************************
// field positions
// ****************************************
`define FCIT_EXT_TIMER_RUN 4
`define FCIT_EXT_SEL_HI 1
`define FCIT_EXT_SEL_LO 0
`define FCIT_FLG_TIMER_EVENT 4
`define FCIT_CTL_TIMER_IRQ_EN 4
`define FCIT_CTL_HALT 1

// ****************************************
// reset values
// ****************************************
`define FCIT_RST_PRESET 12'h001
`define FCIT_RST_EXT 7'h00
`define FCIT_RST_CTL 8'h00

// ****************************************
// timing
// ****************************************
`define FCIT_CLK_NS 20
`define FCIT_RTN_FAST_NS 122000
`define FCIT_RTN_SLOW_NS 7813000
`define FCIT_DIV_4096_MASK 15'h0007
`define FCIT_DIV_64_MASK 15'h01FF
`define FCIT_DIV_1_MASK 15'h7FFF

`endif

// ---- src/fcit_i2c_slave.sv ----
// two-wire serial slave that turns bus bytes into register accesses
`timescale 1ns/1ps
module fcit_i2c_slave
  import fcit_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h51 // arbitrary bus address
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // filtered serial levels and edges
  input wire logic sclRise,
  input wire logic sclFall,
  input wire logic sdaLvl,
  input wire logic startSeen,
  input wire logic stopSeen,
  // data line drive
  output logic sdaOe,
  // register access
  fcit_reg_if.bus rb
);

  fcit_i2c_state_t state_q; // sequencing state
  logic [3:0] bitCnt_q;     // bits done in byte, 8 = ack slot
  logic [7:0] shift_q;      // byte shifter
  logic [7:0] ptr_q;        // register pointer
  logic isRead_q;           // address byte asked for a read
  logic wrStb_q;            // write pulse

  assign rb.wrStb = wrStb_q;
  assign rb.addr = ptr_q;
  assign rb.wrData = shift_q;

  // ****************************************
  // byte sequencing
  // ****************************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= FCIT_ST_IDLE;
      bitCnt_q <= 4'h0;
      shift_q <= 8'h00;
      ptr_q <= 8'h00;
      isRead_q <= 1'b0;
      wrStb_q <= 1'b0;
      sdaOe <= 1'b0;
    end else begin
      wrStb_q <= 1'b0;
      if (stopSeen) begin
        // stop frees the line
        state_q <= FCIT_ST_IDLE;
        sdaOe <= 1'b0;
      end else if (startSeen) begin
        // start or repeated start
        state_q <= FCIT_ST_ADDR;
        bitCnt_q <= 4'h0;
        sdaOe <= 1'b0;
      end else begin
        case (state_q)
          FCIT_ST_ADDR, FCIT_ST_PTR, FCIT_ST_WDATA: begin
            if (sclRise && bitCnt_q < 4'h8) begin
              shift_q <= {shift_q[6:0], sdaLvl};
              bitCnt_q <= bitCnt_q + 4'h1;
              // write lands on the edge that samples the last bit
              if (state_q == FCIT_ST_WDATA && bitCnt_q == 4'h7) begin
                wrStb_q <= 1'b1;
              end
            end else if (sclFall && bitCnt_q == 4'h8) begin
              // ack only our own address
              if (state_q != FCIT_ST_ADDR || shift_q[7:1] == DEV_ADDR) begin
                sdaOe <= 1'b1;
                bitCnt_q <= 4'h9;
                if (state_q == FCIT_ST_ADDR) begin
                  isRead_q <= shift_q[0];
                end else if (state_q == FCIT_ST_PTR) begin
                  ptr_q <= shift_q;
                end else begin
                  ptr_q <= ptr_q + 8'h01;
                end
              end else begin
                state_q <= FCIT_ST_IDLE;
              end
            end else if (sclFall && bitCnt_q == 4'h9) begin
              // ack slot over: next byte
              bitCnt_q <= 4'h0;
              if (state_q == FCIT_ST_ADDR && isRead_q) begin
                state_q <= FCIT_ST_RDATA;
                shift_q <= rb.rdData;
                sdaOe <= ~rb.rdData[7];
              end else begin
                sdaOe <= 1'b0;
                state_q <= (state_q == FCIT_ST_ADDR) ? FCIT_ST_PTR : FCIT_ST_WDATA;
              end
            end
          end
          FCIT_ST_RDATA: begin
            if (sclRise) begin
              bitCnt_q <= bitCnt_q + 4'h1;
            end else if (sclFall) begin
              if (bitCnt_q == 4'h8) begin
                // hand the line to the master for its ack
                sdaOe <= 1'b0;
                state_q <= FCIT_ST_MACK;
              end else begin
                shift_q <= {shift_q[6:0], 1'b0};
                sdaOe <= ~shift_q[6];
              end
            end
          end
          FCIT_ST_MACK: begin
            if (sclRise) begin
              if (sdaLvl) begin
                state_q <= FCIT_ST_IDLE; // nack ends the read
              end else begin
                ptr_q <= ptr_q + 8'h01;
              end
            end else if (sclFall) begin
              // live value is taken afresh for every byte
              state_q <= FCIT_ST_RDATA;
              bitCnt_q <= 4'h0;
              shift_q <= rb.rdData;
              sdaOe <= ~rb.rdData[7];
            end
          end
          FCIT_ST_IDLE: begin
            sdaOe <= 1'b0;
          end
          default: begin
            state_q <= FCIT_ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule

// ---- src/fcit_timer.sv ----
// fixed-cycle interval timer with serial register access and open-drain alert
`timescale 1ns/1ps
`include "fcit_regs.svh"

module fcit_timer
  import fcit_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h51, // arbitrary bus address
  parameter int RTN_FAST_CYC = `FCIT_RTN_FAST_NS / `FCIT_CLK_NS,
  parameter int RTN_SLOW_CYC = `FCIT_RTN_SLOW_NS / `FCIT_CLK_NS
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // crystal and calendar
  input wire logic xtalIn,
  input wire logic minuteTick,
  // serial bus
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // alert pin, open drain
  output logic irqOut,
  output logic irqOe
);

  localparam int RTN_W = $clog2(RTN_SLOW_CYC + 1);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [2:0] sclSync_q; // three-stage sampler
  logic [2:0] sdaSync_q;
  logic [2:0] xtalSync_q;
  logic sclLvl_q;        // accepted levels
  logic sdaLvl_q;
  logic xtalLvl_q;

  // a change counts once stages two and three agree
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sclSync_q <= 3'h7;
      sdaSync_q <= 3'h7;
      xtalSync_q <= 3'h0;
    end else begin
      sclSync_q <= {sclSync_q[1:0], sclIn};
      sdaSync_q <= {sdaSync_q[1:0], sdaIn};
      xtalSync_q <= {xtalSync_q[1:0], xtalIn};
    end
  end

  // filtered levels
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sclLvl_q <= 1'b1;
      sdaLvl_q <= 1'b1;
      xtalLvl_q <= 1'b0;
    end else begin
      if (sclSync_q[1] == sclSync_q[2]) begin
        sclLvl_q <= sclSync_q[2];
      end
      if (sdaSync_q[1] == sdaSync_q[2]) begin
        sdaLvl_q <= sdaSync_q[2];
      end
      if (xtalSync_q[1] == xtalSync_q[2]) begin
        xtalLvl_q <= xtalSync_q[2];
      end
    end
  end

  logic sclNew;  // level about to be accepted
  logic sdaNew;
  logic sclRise; // one-cycle edge pulses
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  logic xtalTick;

  assign sclNew = (sclSync_q[1] == sclSync_q[2]) ? sclSync_q[2] : sclLvl_q;
  assign sdaNew = (sdaSync_q[1] == sdaSync_q[2]) ? sdaSync_q[2] : sdaLvl_q;
  assign sclRise = sclNew & ~sclLvl_q;
  assign sclFall = ~sclNew & sclLvl_q;
  // data moving while clock high marks start and stop
  assign startSeen = sclLvl_q & sclNew & sdaLvl_q & ~sdaNew;
  assign stopSeen = sclLvl_q & sclNew & ~sdaLvl_q & sdaNew;
  assign xtalTick = ((xtalSync_q[1] == xtalSync_q[2]) ? xtalSync_q[2] : xtalLvl_q) & ~xtalLvl_q;

  // ****************************************
  // crystal divider chain
  // ****************************************
  logic [14:0] div_q; // counts crystal edges
  logic tick4096;
  logic tick64;
  logic tick1;

  // free running; the 1 Hz tap ignores the calendar seconds
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= 15'h0000;
    end else if (xtalTick) begin
      div_q <= div_q + 15'h0001;
    end
  end

  assign tick4096 = xtalTick && ((div_q & `FCIT_DIV_4096_MASK) == `FCIT_DIV_4096_MASK);
  assign tick64 = xtalTick && ((div_q & `FCIT_DIV_64_MASK) == `FCIT_DIV_64_MASK);
  assign tick1 = xtalTick && (div_q == `FCIT_DIV_1_MASK);

  // ****************************************
  // register storage
  // ****************************************
  fcit_reg_if rb ();

  logic [11:0] preset_q;  // preset count
  logic [6:0] ext_q;      // extension bits below the test bit
  logic [7:0] ctl_q;      // interrupt control bits
  logic tf_q;             // sticky timer event flag
  logic [11:0] cnt_q;     // live down-counter
  logic timerRun;
  logic irqEnable;
  logic halt;
  fcit_src_t srcSel;
  logic wrExt;
  logic wrFlag;
  logic wrCtl;
  logic runStart;
  logic timerEvent;

  assign timerRun = ext_q[`FCIT_EXT_TIMER_RUN];
  assign irqEnable = ctl_q[`FCIT_CTL_TIMER_IRQ_EN];
  assign halt = ctl_q[`FCIT_CTL_HALT];
  assign srcSel = fcit_src_t'({ext_q[`FCIT_EXT_SEL_HI], ext_q[`FCIT_EXT_SEL_LO]});
  assign wrExt = rb.wrStb && rb.addr == `FCIT_OFF_EXT_CTRL;
  assign wrFlag = rb.wrStb && rb.addr == `FCIT_OFF_EVT_FLAGS;
  assign wrCtl = rb.wrStb && rb.addr == `FCIT_OFF_IRQ_CTRL;
  // run bit going 0 to 1 on the last-bit edge
  assign runStart = wrExt && rb.wrData[`FCIT_EXT_TIMER_RUN] && !timerRun;

  // preset bytes, also plain storage when the timer is idle
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      preset_q <= `FCIT_RST_PRESET;
    end else if (rb.wrStb && rb.addr == `FCIT_OFF_PRESET_LO) begin
      preset_q[7:0] <= rb.wrData;
    end else if (rb.wrStb && rb.addr == `FCIT_OFF_PRESET_HI) begin
      preset_q[11:8] <= rb.wrData[3:0];
    end
  end

  // extension and control bytes; test bit never stored
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ext_q <= `FCIT_RST_EXT;
      ctl_q <= `FCIT_RST_CTL;
    end else begin
      if (wrExt) begin
        ext_q <= rb.wrData[6:0];
      end
      if (wrCtl) begin
        // bits 7, 2 and 0 are not stored and read back as zero
        ctl_q <= {1'b0, rb.wrData[6:3], 1'b0, rb.wrData[1], 1'b0};
      end
    end
  end

  // ****************************************
  // countdown
  // ****************************************
  logic srcTick; // one decrement pulse

  // halt leaves only the fastest source alive
  always_comb begin
    case (srcSel)
      FCIT_SRC_4096: srcTick = tick4096;
      FCIT_SRC_64: srcTick = tick64 && !halt;
      FCIT_SRC_1: srcTick = tick1 && !halt;
      FCIT_SRC_MIN: srcTick = minuteTick && !halt;
      default: srcTick = 1'b0;
    endcase
  end

  // the first tick may fall early inside a period, so an interval
  // can come out one tick short but never long
  assign timerEvent = timerRun && !runStart && srcTick && cnt_q == 12'h001;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= `FCIT_RST_PRESET;
    end else if (runStart) begin
      cnt_q <= preset_q;
    end else if (timerRun && srcTick) begin
      if (cnt_q <= 12'h001) begin
        cnt_q <= preset_q;
      end else begin
        cnt_q <= cnt_q - 12'h001;
      end
    end
  end

  // ****************************************
  // event flag
  // ****************************************
  // an event in the clearing cycle wins over the clear
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tf_q <= 1'b0;
    end else if (timerEvent) begin
      tf_q <= 1'b1;
    end else if (wrFlag && !rb.wrData[`FCIT_FLG_TIMER_EVENT]) begin
      tf_q <= 1'b0;
    end
  end

  // ****************************************
  // alert pin
  // ****************************************
  logic [RTN_W-1:0] rtnCnt_q; // cycles left low
  logic tfClear;
  logic tieClear;

  assign tfClear = wrFlag && !rb.wrData[`FCIT_FLG_TIMER_EVENT] && tf_q;
  assign tieClear = wrCtl && !rb.wrData[`FCIT_CTL_TIMER_IRQ_EN] && irqEnable;

  // stopping the timer lets the release count run out, which is the
  // documented upper bound, rather than cutting the pulse short
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      irqOe <= 1'b0;
      rtnCnt_q <= '0;
    end else if (timerEvent && irqEnable && !tieClear) begin
      irqOe <= 1'b1;
      if (srcSel == FCIT_SRC_4096) begin
        rtnCnt_q <= RTN_W'(RTN_FAST_CYC - 1);
      end else begin
        rtnCnt_q <= RTN_W'(RTN_SLOW_CYC - 1);
      end
    end else if (irqOe && (tfClear || tieClear)) begin
      irqOe <= 1'b0;
    end else if (irqOe) begin
      if (rtnCnt_q == '0) begin
        irqOe <= 1'b0;
      end else begin
        rtnCnt_q <= rtnCnt_q - RTN_W'(1);
      end
    end
  end

  // open-drain pins only ever pull low
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      irqOut <= 1'b0;
      sdaOut <= 1'b0;
    end else begin
      irqOut <= 1'b0;
      sdaOut <= 1'b0;
    end
  end

  // ****************************************
  // read mux
  // ****************************************
  // running reads are live and unlatched, so a byte pair may tear
  always_comb begin
    case (rb.addr)
      `FCIT_OFF_PRESET_LO: rb.rdData = timerRun ? cnt_q[7:0] : preset_q[7:0];
      `FCIT_OFF_PRESET_HI: rb.rdData = {4'h0, timerRun ? cnt_q[11:8] : preset_q[11:8]};
      `FCIT_OFF_EXT_CTRL: rb.rdData = {1'b0, ext_q};
      `FCIT_OFF_EVT_FLAGS: rb.rdData = {3'h0, tf_q, 4'h0};
      `FCIT_OFF_IRQ_CTRL: rb.rdData = ctl_q;
      default: rb.rdData = 8'h00;
    endcase
  end

  // ****************************************
  // serial slave
  // ****************************************
  fcit_i2c_slave #(
    .DEV_ADDR(DEV_ADDR)
  ) u_slave (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .sclRise(sclRise),
    .sclFall(sclFall),
    .sdaLvl(sdaLvl_q),
    .startSeen(startSeen),
    .stopSeen(stopSeen),
    .sdaOe(sdaOe),
    .rb(rb)
  );

endmodule

// ---- tb/fcit_host_model.sv ----
// serial bus host model, open drain with pull-up
`timescale 1ns/1ps
module fcit_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h51 // arbitrary bus address
) (
  // serial pins
  output logic sclIn,
  output logic sdaIn,
  input wire logic sdaOe
);
  logic hostLow; // host pulls data low
  logic nakSeen; // some wrReg or rdReg byte went unanswered
  // wired line: pull-up wins unless either side pulls
  assign sdaIn = ~(hostLow | sdaOe);

  // clock stands high between frames
  initial begin
    sclIn = 1'b1;
    hostLow = 1'b0;
    nakSeen = 1'b0;
  end

  // one bit; slow phases so the pin synchronisers keep order
  task automatic bitx(input logic b, output logic r);
    #200 hostLow = ~b;
    #200 sclIn = 1'b1;
    #390 r = sdaIn;
    #10 sclIn = 1'b0;
  endtask
  // start or repeated start
  task automatic start();
    #200 hostLow = 1'b0;
    #200 sclIn = 1'b1;
    #200 hostLow = 1'b1;
    #200 sclIn = 1'b0;
  endtask
  task automatic stop();
    #200 hostLow = 1'b1;
    #200 sclIn = 1'b1;
    #200 hostLow = 1'b0;
    #200;
  endtask
  task automatic sendByte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    ack = ~r;
  endtask
  task automatic recvByte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, r);
      d[i] = r;
    end
    bitx(last, r);
  endtask
  task automatic wrReg(input logic [7:0] p, input logic [7:0] d);
    logic a, b, c;
    start();
    sendByte({DEV_ADDR, 1'b0}, a);
    sendByte(p, b);
    sendByte(d, c);
    stop();
    if (!(a && b && c)) nakSeen = 1'b1;
  endtask
  // pointer write, repeated start, one byte then no-ack
  task automatic rdReg(input logic [7:0] p, output logic [7:0] d);
    logic a, b, c;
    start();
    sendByte({DEV_ADDR, 1'b0}, a);
    sendByte(p, b);
    start();
    sendByte({DEV_ADDR, 1'b1}, c);
    recvByte(1'b1, d);
    stop();
    if (!(a && b && c)) nakSeen = 1'b1;
  endtask
endmodule

// ---- tb/fcit_timer_assertions.sv ----
// port-level checker of the interval timer
`timescale 1ns/1ps
module fcit_timer_assertions #(
  parameter int RTN_FAST_CYC = 8,
  parameter int RTN_SLOW_CYC = 2000
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // crystal and calendar
  input wire logic xtalIn,
  input wire logic minuteTick,
  // serial bus
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  // alert pin
  input wire logic irqOut,
  input wire logic irqOe
);
  // ****************************************
  // helper counters
  // ****************************************
  logic [4:0] sclHighCnt_q; // clock pin high, saturating; 1F means bus idle
  logic [11:0] irqLen_q; // cycles the alert has been held

  // idle detection: frames never hold the clock high this long
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sclHighCnt_q <= 5'h00;
    end else if (!sclIn) begin
      sclHighCnt_q <= 5'h00;
    end else if (sclHighCnt_q != 5'h1F) begin
      sclHighCnt_q <= sclHighCnt_q + 5'h01;
    end
  end

  // alert length, cleared while released
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      irqLen_q <= 12'h000;
    end else if (irqOe) begin
      irqLen_q <= irqLen_q + 12'h001;
    end else begin
      irqLen_q <= 12'h000;
    end
  end

  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_pins_low: assert property (!irqOut && !sdaOut)
    else $error("open-drain pin driven high");
  a_reset_alert: assert property ($rose(reset_n) |-> !irqOe ##1 !irqOe)
    else $error("alert active after reset");
  a_reset_sda: assert property ($rose(reset_n) |-> !sdaOe ##1 !sdaOe)
    else $error("data line driven after reset");
  a_idle_release: assert property (sclHighCnt_q == 5'h1F |-> !sdaOe)
    else $error("data line held on idle bus");
  a_sda_bit_hold: assert property ($rose(sdaOe) |-> sdaOe [*8])
    else $error("data bit too short");
  a_alert_max: assert property (irqLen_q <= RTN_SLOW_CYC)
    else $error("alert held past release time");
  a_alert_width: assert property (
    $fell(irqOe) && sclHighCnt_q == 5'h1F |->
      (irqLen_q == RTN_FAST_CYC || irqLen_q == RTN_SLOW_CYC))
    else $error("alert width not a release time");
  a_alert_hold: assert property (
    $rose(irqOe) && sclHighCnt_q == 5'h1F |-> irqOe [*8])
    else $error("alert released early");

  // main scenarios reached
  c_alert: cover property ($rose(irqOe));
  c_early: cover property ($fell(irqOe) && sclHighCnt_q != 5'h1F);
  c_ack: cover property ($rose(sdaOe));
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench of the interval timer behind its serial bus
`timescale 1ns/1ps
module tb_top;
  // ****************************************
  // pins and bookkeeping
  // ****************************************
  logic core_clk, reset_n, minuteTick;
  logic xtalIn = 1'b0; // crystal level, driven only by the stand-in below
  logic sclIn, sdaIn, sdaOut, sdaOe, irqOut, irqOe;
  logic [2:0] xtalDiv = 3'h0; // crystal stand-in, 8 cycles a period
  logic [7:0] rdA, rdB;
  logic ack;
  int n, m;
  int errCount, comparisons;

  fcit_timer #(.RTN_FAST_CYC(8), .RTN_SLOW_CYC(2000)) DUT (
    .core_clk(core_clk), .reset_n(reset_n), .xtalIn(xtalIn), .minuteTick(minuteTick),
    .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .irqOut(irqOut), .irqOe(irqOe));
  fcit_host_model host (.sclIn(sclIn), .sdaIn(sdaIn), .sdaOe(sdaOe));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // fast crystal so a 4096 tick is 64 cycles
  always @(posedge core_clk) begin
    xtalDiv <= xtalDiv + 3'h1;
    xtalIn <= xtalDiv[2];
  end

  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errCount++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
    host.rdReg(a, rdA);
    check(rdA, e);
  endtask
  // bounded wait for the alert level, counted in cycles
  task automatic waitIrq(input logic lvl, input int lim, output int c);
    c = 0;
    while (irqOe !== lvl && c < lim) begin
      @(negedge core_clk);
      c++;
    end
  endtask
  task automatic minPulse();
    @(posedge core_clk) minuteTick <= 1'b1;
    @(posedge core_clk) minuteTick <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic testRegs();
    rdChk(8'h0B, 8'h01);
    rdChk(8'h0D, 8'h00);
    rdChk(8'h0E, 8'h00);
    rdChk(8'h0F, 8'h00);
    host.wrReg(8'h0B, 8'hA5);
    host.wrReg(8'h0C, 8'hFF);
    rdChk(8'h0B, 8'hA5);
    rdChk(8'h0C, 8'h0F);
    rdChk(8'h30, 8'h00);
    host.start();
    host.sendByte(8'hA4, ack);
    host.stop();
    check(ack, 1'b0);
    $display("test registers done");
  endtask

  task automatic testPeriodic();
    host.wrReg(8'h0B, 8'h02);
    host.wrReg(8'h0C, 8'h00);
    host.wrReg(8'h0F, 8'h10);
    host.wrReg(8'h0D, 8'h10);
    waitIrq(1'b1, 400, n);
    check(irqOe, 1'b1);
    waitIrq(1'b0, 400, n);
    waitIrq(1'b1, 400, m);
    check(12'(n + m), 12'd128);
    host.wrReg(8'h0D, 8'h00);
    rdChk(8'h0E, 8'h10);
    host.wrReg(8'h0E, 8'h10);
    rdChk(8'h0E, 8'h10);
    host.wrReg(8'h0E, 8'h00);
    rdChk(8'h0E, 8'h00);
    $display("test periodic done");
  endtask

  task automatic testRelease();
    host.wrReg(8'h0B, 8'h01);
    host.wrReg(8'h0D, 8'h11);
    waitIrq(1'b1, 9000, n);
    host.wrReg(8'h0E, 8'h00);
    @(negedge core_clk) check(irqOe, 1'b0);
    waitIrq(1'b1, 9000, n);
    host.wrReg(8'h0F, 8'h00);
    @(negedge core_clk) check(irqOe, 1'b0);
    host.wrReg(8'h0F, 8'h10);
    waitIrq(1'b1, 9000, n);
    host.wrReg(8'h0D, 8'h01);
    @(negedge core_clk) check(irqOe, 1'b1);
    waitIrq(1'b0, 2100, n);
    check(irqOe, 1'b0);
    host.wrReg(8'h0E, 8'h00);
    host.wrReg(8'h0F, 8'h00);
    $display("test release done");
  endtask

  task automatic testLive();
    host.wrReg(8'h0B, 8'hFF);
    host.wrReg(8'h0C, 8'h0F);
    host.wrReg(8'h0D, 8'h10);
    host.rdReg(8'h0B, rdA);
    host.rdReg(8'h0B, rdB);
    check(rdB < rdA && rdA < 8'hFF, 1'b1);
    rdChk(8'h0C, 8'h0F);
    host.wrReg(8'h0D, 8'h00);
    rdChk(8'h0B, 8'hFF);
    host.wrReg(8'h0D, 8'h10);
    host.rdReg(8'h0B, rdA);
    check(rdA > rdB, 1'b1);
    host.wrReg(8'h0D, 8'h00);
    $display("test live count done");
  endtask

  task automatic testSources();
    host.wrReg(8'h0B, 8'h02);
    host.wrReg(8'h0C, 8'h00);
    host.wrReg(8'h0D, 8'h13);
    minPulse();
    host.wrReg(8'h0D, 8'h03);
    host.wrReg(8'h0D, 8'h13);
    minPulse();
    rdChk(8'h0E, 8'h00);
    minPulse();
    rdChk(8'h0E, 8'h10);
    check(irqOe, 1'b0);
    host.wrReg(8'h0E, 8'h00);
    host.wrReg(8'h0F, 8'h02);
    minPulse();
    minPulse();
    rdChk(8'h0E, 8'h00);
    host.wrReg(8'h0D, 8'h10);
    rdChk(8'h0E, 8'h10);
    host.wrReg(8'h0D, 8'h00);
    host.wrReg(8'h0F, 8'h00);
    host.wrReg(8'h0E, 8'h00);
    host.wrReg(8'h0D, 8'h12);
    minPulse();
    minPulse();
    rdChk(8'h0E, 8'h00);
    check(host.nakSeen, 1'b0);
    $display("test sources done");
  endtask

  task automatic printVerdict();
    $display("comparisons %0d mismatches %0d", comparisons, errCount);
    if (errCount == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    reset_n = 1'b0;
    minuteTick = 1'b0;
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    testRegs();
    testPeriodic();
    testRelease();
    testLive();
    testSources();
    printVerdict();
  end

  // hang guard: the scenarios need about 80000 cycles, the guard ends the run at 95000
  initial begin
    repeat (95000) @(posedge core_clk);
    errCount++;
    $display("watchdog ran out");
    printVerdict();
  end
endmodule

bind fcit_timer fcit_timer_assertions #(
  .RTN_FAST_CYC(RTN_FAST_CYC), .RTN_SLOW_CYC(RTN_SLOW_CYC)) chk (
  .core_clk, .reset_n, .xtalIn, .minuteTick, .sclIn,
  .sdaIn, .sdaOut, .sdaOe, .irqOut, .irqOe);
